// ===== hw/fcr_key_check.sv
// key sequence checker: two words in order unlock a region
// assumes: caller presents each key write as a one-cycle strobe
`timescale 1ns/100ps
module fcr_key_check
  import fcr_pkg::*;
#(
  parameter logic [31:0] KEY1 = 32'h11111111,
  parameter logic [31:0] KEY2 = 32'h22222222
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // key writes
  input  wire logic        wr,
  input  wire logic [31:0] data,
  // result
  output logic             unlock
);
  typedef struct packed {
    logic first;
    logic unlock;
  } fcr_kc_s;
  fcr_kc_s st;
  fcr_kc_s next_st;

  always_comb begin
    next_st        = st;
    next_st.unlock = 1'b0;
    if (wr) begin
      if (st.first && data == KEY2) begin
        next_st.unlock = 1'b1;
        next_st.first  = 1'b0;
      end else begin
        // a wrong word restarts the sequence
        next_st.first = (data == KEY1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign unlock = st.unlock;
endmodule : fcr_key_check

// ===== hw/fcr_op_seq.sv
// program and erase sequencer: busy for a fixed time, then a result
// assumes: start is a one-cycle strobe, array behaviour given by inputs
`timescale 1ns/100ps
`include "fcr_regs.svh"
module fcr_op_seq
  import fcr_pkg::*;
#(
  parameter int OP_CYC = `FCR_OP_CYC
) (
  // clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // request
  input  wire logic  start,
  input  wire logic  prot_hit,
  input  wire logic  not_erased,
  // state
  output logic       busy,
  output fcr_result_s result
);
  typedef struct packed {
    fcr_op_e     state;
    logic [15:0] cnt;
    logic        bad;
    fcr_result_s res;
  } fcr_seq_s;
  fcr_seq_s st;
  fcr_seq_s next_st;

  always_comb begin
    next_st     = st;
    next_st.res = '0;
    case (st.state)
      FCR_IDLE: begin
        if (start) begin
          if (prot_hit) begin
            // protected target: no operation, flag only
            next_st.res.prot_err = 1'b1;
          end else begin
            next_st.state = FCR_RUN;
            next_st.cnt   = 16'(OP_CYC - 1);
            next_st.bad   = not_erased;
          end
        end
      end
      FCR_RUN: begin
        if (st.cnt == 16'h0000) begin
          next_st.state = FCR_FINISH;
        end else begin
          next_st.cnt = st.cnt - 16'h0001;
        end
      end
      default: begin
        next_st.state        = FCR_IDLE;
        next_st.res.done     = 1'b1;
        next_st.res.prog_err = st.bad;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{state: FCR_IDLE, cnt: 16'h0000, bad: 1'b0, res: '0};
    end else begin
      st <= next_st;
    end
  end

  assign busy   = (st.state != FCR_IDLE);
  assign result = st.res;
endmodule : fcr_op_seq

// ===== hw/fcr_pkg.sv
// types shared by the flash control register block
// assumes: fcr_regs.svh holds the numbers
package fcr_pkg;
  typedef struct packed {
    logic [11:0] addr;
    logic        write;
    logic [31:0] wdata;
    logic        access;
  } fcr_bus_s;

  typedef enum logic [1:0] {
    FCR_IDLE,
    FCR_RUN,
    FCR_FINISH
  } fcr_op_e;

  typedef struct packed {
    logic        done;
    logic        prot_err;
    logic        prog_err;
  } fcr_result_s;
endpackage : fcr_pkg

// ===== hw/fcr_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes: included by the design modules and by the bench
`ifndef FCR_REGS_SVH
`define FCR_REGS_SVH
`define FCR_OFF_PSR        12'h000
`define FCR_OFF_UNLOCK     12'h004
`define FCR_OFF_USD_UNLOCK 12'h008
`define FCR_OFF_STS        12'h00c
`define FCR_OFF_CTRL       12'h010
`define FCR_OFF_ADDR       12'h014
`define FCR_OFF_USD        12'h01c
`define FCR_OFF_WRITE_PROTECT_BITS       12'h020
`define FCR_OFF_SL_STS0    12'h074
`define FCR_OFF_SL_STS1    12'h078
`define FCR_OFF_SL_PCLR    12'h07c
`define FCR_OFF_SL_MISC    12'h080
`define FCR_OFF_CRC_ADDR   12'h084
`define FCR_OFF_CRC_CTRL   12'h088
`define FCR_OFF_CRC_RES    12'h08c
`define FCR_OFF_SL_PSET    12'h160
`define FCR_OFF_SL_RANGE   12'h164
`define FCR_OFF_EM_SET     12'h168
`define FCR_OFF_BTM_SET    12'h16c
`define FCR_OFF_SL_UNLOCK  12'h170
`define FCR_OFF_IRQ        12'h180
// status and control bit positions
`define FCR_STS_BUSY       0
`define FCR_STS_PRGERR     2
`define FCR_STS_PROTERR    4
`define FCR_STS_DONE       5
`define FCR_CTL_PRG        0
`define FCR_CTL_PAGE_ERASE_SEL     1
`define FCR_CTL_WHOLE_BANK_ERASE_SEL    2
`define FCR_CTL_UPRG       4
`define FCR_CTL_UERS       5
`define FCR_CTL_ERSTRT     6
`define FCR_CTL_OPERATION_LOCK       7
`define FCR_CTL_UDULK      9
`define FCR_CTL_ERROR_IRQ_ENABLE      10
`define FCR_CTL_DONEIE     12
`define FCR_CRC_START      16
// reset values and the sl unlock key
`define FCR_RST_PSR        32'h000001f0
`define FCR_RST_CTRL       32'h00020080
`define FCR_RST_USD        32'h03fffffc
`define FCR_RST_ALL1       32'hffffffff
`define FCR_RST_SL_STS0    32'h00ff0000
`define FCR_SL_KEY         32'ha35f6d24
// timing
`define FCR_CLK_NS         50
`define FCR_OP_NS          1000
`define FCR_OP_CYC         ((`FCR_OP_NS + `FCR_CLK_NS - 1) / `FCR_CLK_NS)
`endif

// ===== hw/fcr_top.sv
// flash controller register interface: apb slave, flags and status
// assumes: word-only apb master, loaded option data on static inputs
//
// Register access over APB was decided locally.
`timescale 1ns/100ps
`include "fcr_regs.svh"
module fcr_top
  import fcr_pkg::*;
#(
  parameter int          OP_CYC  = `FCR_OP_CYC,
  parameter logic [31:0] KEY1    = 32'h11111111,  // arbitrary value
  parameter logic [31:0] KEY2    = 32'h22222222,  // arbitrary value
  parameter int          WAIT_W  = 3
) (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // loaded option data
  input  wire logic [7:0]  opt_access_byte,
  input  wire logic [7:0]  opt_user0,
  input  wire logic [7:0]  opt_user0_inv,
  input  wire logic [7:0]  opt_user1,
  input  wire logic [7:0]  opt_user1_inv,
  input  wire logic [7:0]  opt_setting,
  input  wire logic [7:0]  opt_setting_inv,
  input  wire logic [31:0] opt_write_protect,
  input  wire logic [31:0] opt_sl_status0,
  input  wire logic [31:0] opt_sl_status1,
  // array side
  input  wire logic        target_protected,
  input  wire logic        target_not_erased,
  // flash read path controls, checksum launch and interrupt
  output logic [WAIT_W-1:0] read_wait_states,
  output logic             prefetch_latency_off,
  output logic             prefetch_buffer_on,
  output logic             second_prefetch_on,
  output logic             checksum_launch_pulse,
  output logic             irq
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [31:0] psr;
    logic [31:0] sts;
    logic [31:0] ctrl;
    logic [31:0] erase_addr;
    logic [31:0] crc_addr;
    logic [15:0] crc_count;
    logic        crc_go;
    logic        sl_unlocked;
    logic        ready;
    logic [31:0] rdata;
    logic        irq;
    logic        slverr;
  } fcr_top_s;
  fcr_top_s st;
  fcr_top_s next_st;

  logic        wr_acc;
  logic        rd_acc;
  logic        key_wr;
  logic        ukey_wr;
  logic        arr_unlock;
  logic        usd_unlock;
  logic        op_start;
  logic        op_busy;
  fcr_result_s op_res;
  logic        mism0;
  logic        mism1;
  logic        mism2;
  logic [31:0] usd_view;
  logic [31:0] rd_mux;
  logic        mapped;

  // setup ends with the access phase; one wait cycle per access
  assign wr_acc  = psel && penable && pwrite && !st.ready;
  assign rd_acc  = psel && penable && !pwrite && !st.ready;
  assign key_wr  = wr_acc && paddr == `FCR_OFF_UNLOCK;
  assign ukey_wr = wr_acc && paddr == `FCR_OFF_USD_UNLOCK;

  // ****************************************
  // key checkers and sequencer
  // ****************************************
  fcr_key_check #(.KEY1(KEY1), .KEY2(KEY2)) u_arr_key (
    .pclk    (pclk),
    .presetn (presetn),
    .wr      (key_wr),
    .data    (pwdata),
    .unlock  (arr_unlock)
  );

  fcr_key_check #(.KEY1(KEY1), .KEY2(KEY2)) u_usd_key (
    .pclk    (pclk),
    .presetn (presetn),
    .wr      (ukey_wr),
    .data    (pwdata),
    .unlock  (usd_unlock)
  );

  // an erase trigger (page, bank, or user data with UDULK) starts when unlocked and the sequencer is idle
  always_comb begin
    op_start = 1'b0;
    if (wr_acc && paddr == `FCR_OFF_CTRL && !st.ctrl[`FCR_CTL_OPERATION_LOCK]
        && !op_busy) begin
      op_start = pwdata[`FCR_CTL_ERSTRT] &&
                 (pwdata[`FCR_CTL_PAGE_ERASE_SEL] || pwdata[`FCR_CTL_WHOLE_BANK_ERASE_SEL] ||
                  (pwdata[`FCR_CTL_UERS] &&
                   st.ctrl[`FCR_CTL_UDULK]));
    end
  end

  fcr_op_seq #(.OP_CYC(OP_CYC)) u_seq (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (op_start),
    .prot_hit   (target_protected),
    .not_erased (target_not_erased),
    .busy       (op_busy),
    .result     (op_res)
  );

  // ****************************************
  // user system data view
  // ****************************************
  assign mism0 = (opt_user0 != ~opt_user0_inv);
  assign mism1 = (opt_user1 != ~opt_user1_inv);
  assign mism2 = (opt_setting != ~opt_setting_inv);
  always_comb begin
    usd_view        = '0;
    usd_view[26]    = (opt_access_byte == 8'hcc);
    usd_view[1]     = (opt_access_byte != 8'ha5);
    usd_view[25:18] = mism1 ? 8'hff : opt_user1;
    usd_view[17:10] = mism0 ? 8'hff : opt_user0;
    usd_view[9:2]   = mism2 ? 8'hff : opt_setting;
    usd_view[0]     = mism0 || mism1 || mism2;
  end

  // ****************************************
  // read decode
  // ****************************************
  always_comb begin
    rd_mux = '0;
    mapped = 1'b1;
    if (paddr == `FCR_OFF_PSR) begin
      rd_mux = st.psr;
    end else if (paddr == `FCR_OFF_STS) begin
      rd_mux = st.sts;
    end else if (paddr == `FCR_OFF_CTRL) begin
      rd_mux = st.ctrl;
    end else if (paddr == `FCR_OFF_USD) begin
      rd_mux = usd_view;
    end else if (paddr == `FCR_OFF_WRITE_PROTECT_BITS) begin
      rd_mux = opt_write_protect;
    end else if (paddr == `FCR_OFF_SL_STS0) begin
      rd_mux = opt_sl_status0 & 32'h00ff000d;
    end else if (paddr == `FCR_OFF_SL_STS1) begin
      rd_mux = opt_sl_status1;
    end else if (paddr == `FCR_OFF_SL_MISC) begin
      rd_mux = {29'h0, st.sl_unlocked, 2'h0};
    end else if (paddr == `FCR_OFF_IRQ) begin
      rd_mux = {31'h0, st.irq};
    end else if (paddr == `FCR_OFF_UNLOCK || paddr == `FCR_OFF_USD_UNLOCK
                 || paddr == `FCR_OFF_ADDR || paddr == `FCR_OFF_SL_PCLR
                 || paddr == `FCR_OFF_CRC_ADDR || paddr == `FCR_OFF_CRC_CTRL
                 || paddr == `FCR_OFF_CRC_RES || paddr == `FCR_OFF_SL_PSET
                 || paddr == `FCR_OFF_SL_RANGE || paddr == `FCR_OFF_EM_SET
                 || paddr == `FCR_OFF_BTM_SET
                 || paddr == `FCR_OFF_SL_UNLOCK) begin
      rd_mux = '0;
    end else begin
      mapped = 1'b0;
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st        = st;
    next_st.ready  = (psel && penable && !st.ready);
    // pslverr only for unmapped; word-only access is the master's duty
    next_st.slverr = psel && penable && !st.ready && !mapped;
    next_st.crc_go = 1'b0;
    if (rd_acc) begin
      next_st.rdata = rd_mux;
    end
    if (wr_acc) begin
      if (paddr == `FCR_OFF_PSR) begin
        next_st.psr[8]   = pwdata[8];
        next_st.psr[6]   = pwdata[6];
        next_st.psr[4]   = pwdata[4];
        next_st.psr[2:0] = pwdata[2:0];
      end else if (paddr == `FCR_OFF_STS) begin
        // write one clears; hardware set below wins
        next_st.sts[5] = st.sts[5] && !pwdata[5];
        next_st.sts[4] = st.sts[4] && !pwdata[4];
        next_st.sts[2] = st.sts[2] && !pwdata[2];
      end else if (paddr == `FCR_OFF_CTRL) begin
        next_st.ctrl[12] = pwdata[12];
        next_st.ctrl[10] = pwdata[10];
        next_st.ctrl[5:4] = pwdata[5:4];
        next_st.ctrl[2:0] = pwdata[2:0];
        if (!pwdata[9]) begin
          next_st.ctrl[9] = 1'b0;
        end
        if (pwdata[7]) begin
          next_st.ctrl[7] = 1'b1;
        end
        next_st.ctrl[6] = op_start;
      end else if (paddr == `FCR_OFF_ADDR) begin
        next_st.erase_addr = pwdata;
      end else if (paddr == `FCR_OFF_CRC_ADDR) begin
        next_st.crc_addr = pwdata;
      end else if (paddr == `FCR_OFF_CRC_CTRL) begin
        next_st.crc_count = pwdata[15:0];
        next_st.crc_go    = pwdata[`FCR_CRC_START];
      end else if (paddr == `FCR_OFF_SL_UNLOCK) begin
        next_st.sl_unlocked = (pwdata == `FCR_SL_KEY);
      end
    end
    // prefetch enabled flags follow their enables
    next_st.psr[7] = next_st.psr[6];
    next_st.psr[5] = next_st.psr[4];
    if (arr_unlock) begin
      next_st.ctrl[7] = 1'b0;
    end
    if (usd_unlock) begin
      next_st.ctrl[9] = 1'b1;
    end
    // a blocked operation never shows busy
    next_st.sts[0] = op_busy || (op_start && !target_protected);
    if (op_res.done) begin
      next_st.sts[5]  = 1'b1;
      next_st.ctrl[6] = 1'b0;
    end
    if (op_res.prot_err) begin
      next_st.sts[4]  = 1'b1;
      next_st.ctrl[6] = 1'b0;
    end
    if (op_res.prog_err) begin
      next_st.sts[2] = 1'b1;
    end
    next_st.irq = (next_st.sts[5] && next_st.ctrl[12]) ||
                  ((next_st.sts[4] || next_st.sts[2]) &&
                   next_st.ctrl[10]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{psr: `FCR_RST_PSR, sts: 32'h00000000,
              ctrl: `FCR_RST_CTRL, erase_addr: 32'h00000000,
              crc_addr: 32'h00000000, crc_count: 16'h0000,
              crc_go: 1'b0, sl_unlocked: 1'b0, ready: 1'b0,
              rdata: 32'h00000000, irq: 1'b0, slverr: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata                = st.rdata;
  assign pready                = st.ready;
  assign pslverr               = st.slverr;
  assign read_wait_states      = st.psr[WAIT_W-1:0];
  assign prefetch_latency_off  = st.psr[8];
  assign prefetch_buffer_on    = st.psr[5];
  assign second_prefetch_on    = st.psr[7];
  assign checksum_launch_pulse = st.crc_go;
  assign irq                   = st.irq;

  // ****************************************
  // checks
  // ****************************************
  property p_lock_blocks;
    @(posedge pclk) disable iff (!presetn)
    (st.ctrl[7] && !op_busy) |=> !op_busy;
  endproperty
  a_lock_blocks: assert property (p_lock_blocks)
    else $error("operation ran while locked");

  property p_done_sets;
    @(posedge pclk) disable iff (!presetn)
    op_res.done |=> st.sts[5];
  endproperty
  a_done_sets: assert property (p_done_sets)
    else $error("done flag not set");

  property p_busy;
    @(posedge pclk) disable iff (!presetn)
    op_start && !target_protected |=> st.sts[0] ##1 st.sts[0];
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy not raised");

  property p_prot;
    @(posedge pclk) disable iff (!presetn)
    op_res.prot_err |=> st.sts[4] && !st.sts[0];
  endproperty
  a_prot: assert property (p_prot)
    else $error("protection error not flagged");

  property p_pf_flag;
    @(posedge pclk) disable iff (!presetn)
    st.psr[5] == st.psr[4] && st.psr[7] == st.psr[6];
  endproperty
  a_pf_flag: assert property (p_pf_flag)
    else $error("prefetch flag mismatch");

  property p_crc;
    @(posedge pclk) disable iff (!presetn)
    st.crc_go |=> !st.crc_go;
  endproperty
  a_crc: assert property (p_crc)
    else $error("checksum launch stuck");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
    (st.sts[5] && st.ctrl[12]) |-> st.irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("done interrupt missing");

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready;
  endproperty
  a_ready: assert property (p_ready)
    else $error("no answer after one wait");

  c_erase: cover property (@(posedge pclk) op_res.done);
  c_prot: cover property (@(posedge pclk) op_res.prot_err);
  c_unlock: cover property (@(posedge pclk) arr_unlock);
endmodule : fcr_top

// ===== tb/fcr_tb.sv
// self-checking bench for the flash control register block
// assumes: fcr_top reached over apb, option data driven as levels
`timescale 1ns/100ps
`include "fcr_regs.svh"
module tb;
  import fcr_pkg::*;
  // short op count keeps the busy window brief but still pollable
  localparam int          OPC = 8;
  localparam logic [31:0] K1  = 32'h5ac3e1d7;  // arbitrary value
  localparam logic [31:0] K2  = 32'h3c69b24e;  // arbitrary value
  localparam logic [31:0] ALL = 32'hffffffff;
  localparam logic [31:0] CTM = 32'h000016f7;
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  ab  = 8'ha5;
  logic [7:0]  u0  = 8'hff;
  logic [7:0]  u0i = 8'h00;
  logic [7:0]  u1  = 8'hff;
  logic [7:0]  u1i = 8'h00;
  logic [7:0]  ss  = 8'hff;
  logic [7:0]  ssi = 8'h00;
  logic [31:0] write_protect_bits = ALL;
  logic [31:0] sl0  = 32'h00ff0000;
  logic [31:0] sl1  = ALL;
  logic        prot = 1'b0;
  logic        ne   = 1'b0;
  logic [2:0]  rws;
  logic        plo;
  logic        pb1;
  logic        pb2;
  logic        crc_p;
  logic        irq;
  logic [31:0] lfsr = 32'hf50a;
  logic [31:0] mdl [int];
  int          err_total    = 0;
  int          total_checks = 0;
  int          crc_n        = 0;

  always #25 pclk = ~pclk;

  always @(posedge pclk) begin
    if (crc_p === 1'b1) crc_n++;
  end

  fcr_top #(.OP_CYC(OPC), .KEY1(K1), .KEY2(K2), .WAIT_W(3)) fcr_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .opt_access_byte(ab),
    .opt_user0(u0), .opt_user0_inv(u0i), .opt_user1(u1),
    .opt_user1_inv(u1i), .opt_setting(ss), .opt_setting_inv(ssi),
    .opt_write_protect(write_protect_bits), .opt_sl_status0(sl0),
    .opt_sl_status1(sl1), .target_protected(prot),
    .target_not_erased(ne), .read_wait_states(rws),
    .prefetch_latency_off(plo), .prefetch_buffer_on(pb1),
    .second_prefetch_on(pb2), .checksum_launch_pulse(crc_p), .irq(irq));

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  // a byte failing its inverse reads as all ones and raises the error bit
  function automatic logic [31:0] usd_exp();
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
    logic       e;
    a = (u1 === ~u1i) ? u1 : 8'hff;
    b = (u0 === ~u0i) ? u0 : 8'hff;
    c = (ss === ~ssi) ? ss : 8'hff;
    e = (u0 !== ~u0i) || (u1 !== ~u1i) || (ss !== ~ssi);
    return {5'h0, ab == 8'hcc, a, b, c, ab != 8'ha5, e};
  endfunction : usd_exp

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic se);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    rd      = prdata;
    se      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic        e;
    apb(1'b1, a, v, d, e);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] m);
    logic [31:0] d;
    logic        e;
    apb(1'b0, a, 32'h0, d, e);
    chk($sformatf("slverr %h", a), 32'h0, {31'h0, e});
    chk($sformatf("reg %h", a), mdl[a] & m, d & m);
  endtask : rdc

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    #1000000;
    err_total++;
    final_report();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    logic [31:0] d;
    logic [31:0] w;
    logic        e;
    int          n;
    logic [11:0] rl[$];
    rl = '{`FCR_OFF_PSR, `FCR_OFF_UNLOCK, `FCR_OFF_USD_UNLOCK,
           `FCR_OFF_STS, `FCR_OFF_CTRL, `FCR_OFF_ADDR, `FCR_OFF_USD,
           `FCR_OFF_WRITE_PROTECT_BITS, `FCR_OFF_SL_STS0, `FCR_OFF_SL_STS1,
           `FCR_OFF_SL_MISC, `FCR_OFF_CRC_RES, `FCR_OFF_SL_PSET,
           `FCR_OFF_SL_RANGE, `FCR_OFF_SL_UNLOCK, `FCR_OFF_IRQ};
    foreach (rl[i]) mdl[rl[i]] = 32'h0;
    mdl[`FCR_OFF_PSR]     = `FCR_RST_PSR;
    mdl[`FCR_OFF_CTRL]    = `FCR_RST_CTRL;
    mdl[`FCR_OFF_USD]     = `FCR_RST_USD;
    mdl[`FCR_OFF_WRITE_PROTECT_BITS]    = ALL;
    mdl[`FCR_OFF_SL_STS0] = `FCR_RST_SL_STS0;
    mdl[`FCR_OFF_SL_STS1] = ALL;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rl[i]) rdc(rl[i], ALL);
    apb(1'b0, 12'h300, 32'h0, d, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, d);
    for (int i = 0; i < 6; i++) begin
      w = rnd();
      wr(`FCR_OFF_PSR, w);
      mdl[`FCR_OFF_PSR] = {23'h0, w[8], w[6], w[6], w[4], w[4], 1'b0, w[2:0]};
      rdc(`FCR_OFF_PSR, ALL);
      chk("wait", {29'h0, w[2:0]}, {29'h0, rws});
      chk("latency", {31'h0, w[8]}, {31'h0, plo});
      chk("pf", {30'h0, w[6], w[4]}, {30'h0, pb2, pb1});
    end
    // option data: valid, high, low protection, then inverse faults
    for (int i = 0; i < 6; i++) begin
      w = rnd();
      ab   <= (i % 3 == 0) ? 8'ha5 : (i % 3 == 1) ? 8'hcc : w[31:24];
      u0   <= w[7:0];
      u0i  <= (i == 4) ? w[7:0] : ~w[7:0];
      u1   <= w[15:8];
      u1i  <= ~w[15:8];
      ss   <= w[23:16];
      ssi  <= (i == 5) ? w[23:16] ^ 8'h01 : ~w[23:16];
      write_protect_bits <= rnd();
      sl0  <= rnd();
      sl1  <= rnd();
      repeat (2) @(posedge pclk);
      mdl[`FCR_OFF_USD]     = usd_exp();
      mdl[`FCR_OFF_WRITE_PROTECT_BITS]    = write_protect_bits;
      mdl[`FCR_OFF_SL_STS0] = sl0;
      mdl[`FCR_OFF_SL_STS1] = sl1;
      rdc(`FCR_OFF_USD, ALL);
      rdc(`FCR_OFF_WRITE_PROTECT_BITS, ALL);
      rdc(`FCR_OFF_SL_STS0, 32'h00ff000d);
      rdc(`FCR_OFF_SL_STS1, ALL);
    end
    wr(`FCR_OFF_CTRL, 32'h00000042);
    rdc(`FCR_OFF_STS, ALL);
    wr(`FCR_OFF_CTRL, 32'h0);
    wr(`FCR_OFF_UNLOCK, K2);
    rdc(`FCR_OFF_CTRL, 32'h80);
    wr(`FCR_OFF_UNLOCK, K1);
    wr(`FCR_OFF_UNLOCK, K2);
    mdl[`FCR_OFF_CTRL] = 32'h0;
    rdc(`FCR_OFF_CTRL, CTM);
    prot <= 1'b1;
    wr(`FCR_OFF_CTRL, 32'h00001442);
    mdl[`FCR_OFF_STS] = 32'h10;
    rdc(`FCR_OFF_STS, ALL);
    chk("irq err", 32'h1, {31'h0, irq});
    wr(`FCR_OFF_STS, 32'h10);
    mdl[`FCR_OFF_STS] = 32'h0;
    rdc(`FCR_OFF_STS, ALL);
    chk("irq off", 32'h0, {31'h0, irq});
    prot <= 1'b0;
    wr(`FCR_OFF_CTRL, 32'h00001000);
    wr(`FCR_OFF_ADDR, 32'h08001000);
    wr(`FCR_OFF_CTRL, 32'h00001042);
    mdl[`FCR_OFF_STS] = 32'h1;
    rdc(`FCR_OFF_STS, ALL);
    n = 0;
    do begin
      apb(1'b0, `FCR_OFF_STS, 32'h0, d, e);
      n++;
    end while (d[0] !== 1'b0 && n < 20);
    chk("busy end", 32'h0, {31'h0, d[0]});
    mdl[`FCR_OFF_STS]  = 32'h20;
    mdl[`FCR_OFF_CTRL] = 32'h00001002;
    mdl[`FCR_OFF_IRQ]  = 32'h1;
    rdc(`FCR_OFF_STS, ALL);
    rdc(`FCR_OFF_CTRL, CTM);
    rdc(`FCR_OFF_IRQ, ALL);
    wr(`FCR_OFF_STS, 32'h20);
    mdl[`FCR_OFF_STS] = 32'h0;
    mdl[`FCR_OFF_IRQ] = 32'h0;
    rdc(`FCR_OFF_STS, ALL);
    rdc(`FCR_OFF_IRQ, ALL);
    // target not erased: error flag beside done, error interrupt only
    ne <= 1'b1;
    wr(`FCR_OFF_CTRL, 32'h00000442);
    repeat (3 * OPC) @(posedge pclk);
    mdl[`FCR_OFF_STS] = 32'h24;
    rdc(`FCR_OFF_STS, ALL);
    chk("irq prog", 32'h1, {31'h0, irq});
    wr(`FCR_OFF_STS, 32'h24);
    ne <= 1'b0;
    mdl[`FCR_OFF_STS] = 32'h0;
    rdc(`FCR_OFF_STS, ALL);
    chk("irq prog off", 32'h0, {31'h0, irq});
    wr(`FCR_OFF_CTRL, 32'h00000080);
    wr(`FCR_OFF_USD_UNLOCK, K1);
    wr(`FCR_OFF_USD_UNLOCK, K2);
    mdl[`FCR_OFF_CTRL] = 32'h00000280;
    rdc(`FCR_OFF_CTRL, CTM);
    wr(`FCR_OFF_CTRL, 32'h00000080);
    mdl[`FCR_OFF_CTRL] = 32'h00000080;
    rdc(`FCR_OFF_CTRL, CTM);
    wr(`FCR_OFF_SL_UNLOCK, `FCR_SL_KEY);
    mdl[`FCR_OFF_SL_MISC] = 32'h4;
    rdc(`FCR_OFF_SL_MISC, ALL);
    wr(`FCR_OFF_SL_UNLOCK, rnd());
    mdl[`FCR_OFF_SL_MISC] = 32'h0;
    rdc(`FCR_OFF_SL_MISC, ALL);
    wr(`FCR_OFF_CRC_CTRL, 32'h00010004);
    repeat (6) @(posedge pclk);
    chk("launch pulses", 32'h1, crc_n);
    final_report();
  end
endmodule : tb
